// file: hw/idcfg_bank.sv
// Identification configuration bank: validity byte, vendor and product codes, source choice.
// Assumes a byte-wide register port from the SMBus slave, a byte stream from the EEPROM
// reader, and OTP identifier values that are stable after reset.
// Functional notes
// [RULE1] In I2C mode the first EEPROM byte is compared with 55h to judge whether the EEPROM is programmed.
// [RULE2] If the first EEPROM byte is not 55h the load stops and every register keeps its default.
// [RULE3] The vendor code is sixteen bits, low byte at offset 1h and high byte at offset 2h.
// [RULE4] The product code is sixteen bits, low byte at 3h and high byte at 4h, reported whole for SuperSpeed.
// [RULE5] The USB 2.0 product code has its low byte XORed with 00000010b, flipping only bit 1.
// [RULE6] When both written vendor and product codes are non-zero, all four bytes come from the written values.
// [RULE7] When the written codes are zero, the non-zero codes from OTP memory are used instead.
// [RULE8] When OTP also holds zero, the built-in default codes are used.
// [RULE9] The EEPROM image or SMBus host may overwrite the vendor code and the bank accepts it.
// [RULE10] The validity byte is an eight-bit read-write register cleared to zero at reset.
// [RULE11] Registers are accessed a byte at a time, start at defaults, and are writable only in I2C or SMBus mode.
// [RULE12] The source is chosen on full sixteen-bit vendor and product values, one source for all four bytes.
`timescale 1ns/1ps
module idcfg_bank #(
  parameter logic [15:0] DEFAULT_VENDOR = 16'h1A2B,   // Arbitrary value.
  parameter logic [15:0] DEFAULT_PRODUCT = 16'h3C4D   // Arbitrary value.
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire idcfg_pkg::idcfg_mode_t CFG_MODE_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [idcfg_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [idcfg_pkg::DATA_W-1:0] WDATA_IN,
  output logic [idcfg_pkg::DATA_W-1:0] RDATA_OUT,
  output logic RVALID_OUT,
  input wire logic EE_START_IN,
  input wire logic EE_VALID_IN,
  input wire logic [idcfg_pkg::DATA_W-1:0] EE_BYTE_IN,
  output logic EE_READY_OUT,
  output logic LOAD_DONE_OUT,
  output logic LOAD_ABORT_OUT,
  input wire logic [idcfg_pkg::ID_W-1:0] OTP_VENDOR_IN,
  input wire logic [idcfg_pkg::ID_W-1:0] OTP_PRODUCT_IN,
  output logic [idcfg_pkg::ID_W-1:0] VENDOR_CODE_OUT,
  output logic [idcfg_pkg::ID_W-1:0] PRODUCT_SS_OUT,
  output logic [idcfg_pkg::ID_W-1:0] PRODUCT_USB2_OUT,
  output idcfg_pkg::idcfg_src_t SOURCE_OUT
);
  import idcfg_pkg::*;

  // A zero default would make the last fallback indistinguishable from "nothing set".
  if (DEFAULT_VENDOR == 16'h0000 || DEFAULT_PRODUCT == 16'h0000) begin : g_bad_default
    $error("idcfg_bank: default codes must be non-zero");
  end

  function automatic logic [7:0] pick_byte(input logic [7:0] off, input logic [7:0] valid_b,
                                           input logic [15:0] ven, input logic [15:0] prod);
    case (off)
      OFF_VALIDITY: pick_byte = valid_b;
      OFF_VENDOR_LO: pick_byte = ven[7:0];
      OFF_VENDOR_HI: pick_byte = ven[15:8];
      OFF_PRODUCT_LO: pick_byte = prod[7:0];
      OFF_PRODUCT_HI: pick_byte = prod[15:8];
      default: pick_byte = READ_UNMAPPED;
    endcase
  endfunction : pick_byte

  // Both halves must be non-zero; a half-written pair never selects its source.
  function automatic logic pair_set(input logic [15:0] ven, input logic [15:0] prod);
    pair_set = (ven != 16'h0000) && (prod != 16'h0000);
  endfunction : pair_set

  logic [7:0] eeprom_validity_byte;
  logic [15:0] vendor_code_written;
  logic [15:0] product_code_written;
  idcfg_load_t load_state;
  logic [7:0] load_off;
  logic [15:0] vendor_code;
  logic [15:0] product_code;
  idcfg_src_t source;
  logic cfg_mode_ok;
  logic ee_take;
  logic ee_sig_ok;
  logic host_wr;
  logic ld_wr;
  logic [7:0] wr_off;
  logic [7:0] wr_data;

  assign cfg_mode_ok = (CFG_MODE_IN == IDCFG_MODE_I2C) || (CFG_MODE_IN == IDCFG_MODE_SMBUS);
  assign EE_READY_OUT = (load_state == IDCFG_LD_SIG) || (load_state == IDCFG_LD_DATA);
  assign ee_take = EE_READY_OUT && EE_VALID_IN;
  assign ee_sig_ok = (EE_BYTE_IN == VALIDITY_PATTERN);                  // [RULE1]

  // The loader owns the bank on every byte it takes, a rejected signature included;
  // a host write in that cycle is dropped so an abort always leaves clean defaults.
  assign ld_wr = ee_take && (load_state == IDCFG_LD_DATA || ee_sig_ok);
  assign host_wr = WR_EN_IN && cfg_mode_ok && !ee_take;                 // [RULE11]
  assign wr_off = ld_wr ? load_off : ADDR_IN;
  assign wr_data = ld_wr ? EE_BYTE_IN : WDATA_IN;

  // EEPROM load sequence: signature check, then the four identifier bytes.
  // Starts outside I2C mode are ignored: only in that mode is the EEPROM read at all.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      load_state <= IDCFG_LD_IDLE;
      load_off <= OFF_VALIDITY;
      LOAD_DONE_OUT <= 1'b0;
      LOAD_ABORT_OUT <= 1'b0;
    end else begin
      case (load_state)
        IDCFG_LD_IDLE, IDCFG_LD_DONE: begin
          if (EE_START_IN && CFG_MODE_IN == IDCFG_MODE_I2C) begin
            load_state <= IDCFG_LD_SIG;
            load_off <= OFF_VALIDITY;
            LOAD_DONE_OUT <= 1'b0;
            LOAD_ABORT_OUT <= 1'b0;
          end
        end
        IDCFG_LD_SIG: begin
          if (ee_take) begin
            if (ee_sig_ok) begin                                        // [RULE1]
              load_state <= IDCFG_LD_DATA;
              load_off <= OFF_VENDOR_LO;
            end else begin
              load_state <= IDCFG_LD_DONE;                              // [RULE2]
              LOAD_DONE_OUT <= 1'b1;
              LOAD_ABORT_OUT <= 1'b1;
            end
          end
        end
        IDCFG_LD_DATA: begin
          if (ee_take) begin
            if (load_off == OFF_LAST) begin
              load_state <= IDCFG_LD_DONE;
              LOAD_DONE_OUT <= 1'b1;
            end else begin
              load_off <= load_off + 8'h01;
            end
          end
        end
        default: load_state <= IDCFG_LD_IDLE;
      endcase
    end
  end

  // Written image; zero means "not written", which drives the source choice.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      eeprom_validity_byte <= VALIDITY_RESET;                           // [RULE10]
      vendor_code_written <= WRITTEN_RESET;
      product_code_written <= WRITTEN_RESET;
    end else if (ee_take && load_state == IDCFG_LD_SIG && !ee_sig_ok) begin
      eeprom_validity_byte <= VALIDITY_RESET;                           // [RULE2]
      vendor_code_written <= WRITTEN_RESET;
      product_code_written <= WRITTEN_RESET;
    end else if (ld_wr || host_wr) begin
      case (wr_off)
        OFF_VALIDITY: eeprom_validity_byte <= wr_data;                  // [RULE10]
        OFF_VENDOR_LO: vendor_code_written[7:0] <= wr_data;             // [RULE3] [RULE9]
        OFF_VENDOR_HI: vendor_code_written[15:8] <= wr_data;            // [RULE3] [RULE9]
        OFF_PRODUCT_LO: product_code_written[7:0] <= wr_data;           // [RULE4]
        OFF_PRODUCT_HI: product_code_written[15:8] <= wr_data;          // [RULE4]
        default: ;
      endcase
    end
  end

  // One source for all four bytes, judged on the whole sixteen-bit values.
  always_comb begin
    if (pair_set(vendor_code_written, product_code_written)) begin
      source = IDCFG_SRC_WRITTEN;                                       // [RULE6] [RULE12]
      vendor_code = vendor_code_written;
      product_code = product_code_written;
    end else if (pair_set(OTP_VENDOR_IN, OTP_PRODUCT_IN)) begin
      source = IDCFG_SRC_OTP;                                           // [RULE7] [RULE12]
      vendor_code = OTP_VENDOR_IN;
      product_code = OTP_PRODUCT_IN;
    end else begin
      source = IDCFG_SRC_DEFAULT;                                       // [RULE8]
      vendor_code = DEFAULT_VENDOR;
      product_code = DEFAULT_PRODUCT;
    end
  end

  // Descriptor values are registered so they cannot glitch while a byte is written.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      VENDOR_CODE_OUT <= DEFAULT_VENDOR;
      PRODUCT_SS_OUT <= DEFAULT_PRODUCT;
      PRODUCT_USB2_OUT <= DEFAULT_PRODUCT ^ {8'h00, USB2_PRODUCT_XOR};
      SOURCE_OUT <= IDCFG_SRC_DEFAULT;
    end else begin
      VENDOR_CODE_OUT <= vendor_code;
      PRODUCT_SS_OUT <= product_code;                                   // [RULE4]
      PRODUCT_USB2_OUT <= {product_code[15:8], product_code[7:0] ^ USB2_PRODUCT_XOR}; // [RULE5]
      SOURCE_OUT <= source;
    end
  end

  // Byte reads answer one cycle later; identifier offsets show the value in use.
  // Reads never stall, so the host may strobe back to back on every cycle.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= READ_UNMAPPED;
      RVALID_OUT <= 1'b0;
    end else begin
      RVALID_OUT <= RD_EN_IN;                                           // [RULE11]
      if (RD_EN_IN) begin
        RDATA_OUT <= pick_byte(ADDR_IN, eeprom_validity_byte, vendor_code, product_code);
      end
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_sig_mismatch_abort: assert property ( // [RULE2]
    (load_state == IDCFG_LD_SIG && EE_VALID_IN && EE_BYTE_IN != VALIDITY_PATTERN)
      |=> LOAD_ABORT_OUT && LOAD_DONE_OUT && vendor_code_written == 16'h0000)
    else $error("bad signature did not abort the load");
  a_sig_match_go: assert property ( // [RULE1]
    (load_state == IDCFG_LD_SIG && EE_VALID_IN && EE_BYTE_IN == VALIDITY_PATTERN)
      |=> load_state == IDCFG_LD_DATA && eeprom_validity_byte == VALIDITY_PATTERN)
    else $error("good signature did not start the data phase");
  a_usb2_bit_flip: assert property ( // [RULE5]
    PRODUCT_USB2_OUT == (PRODUCT_SS_OUT ^ 16'h0002))
    else $error("USB 2.0 product code is not the SuperSpeed code with bit 1 flipped");
  a_written_source: assert property ( // [RULE6]
    (vendor_code_written != 16'h0000 && product_code_written != 16'h0000)
      |=> VENDOR_CODE_OUT == $past(vendor_code_written) && SOURCE_OUT == IDCFG_SRC_WRITTEN)
    else $error("written codes were not used");
  a_otp_source: assert property ( // [RULE7]
    (vendor_code_written == 16'h0000 && OTP_VENDOR_IN != 16'h0000 && OTP_PRODUCT_IN != 16'h0000)
      |=> PRODUCT_SS_OUT == $past(OTP_PRODUCT_IN) && SOURCE_OUT == IDCFG_SRC_OTP)
    else $error("OTP codes were not used");
  a_default_source: assert property ( // [RULE8]
    (product_code_written == 16'h0000 && OTP_VENDOR_IN == 16'h0000)
      |=> VENDOR_CODE_OUT == DEFAULT_VENDOR && PRODUCT_SS_OUT == DEFAULT_PRODUCT)
    else $error("defaults were not used");
  a_mode_blocks_wr: assert property ( // [RULE11]
    (WR_EN_IN && CFG_MODE_IN == IDCFG_MODE_PINS && load_state == IDCFG_LD_IDLE)
      |=> $stable(vendor_code_written) && $stable(eeprom_validity_byte))
    else $error("write accepted outside a configuration mode");
  a_vendor_lo_wr: assert property ( // [RULE3] [RULE9]
    (host_wr && ADDR_IN == OFF_VENDOR_LO) |=> vendor_code_written[7:0] == $past(WDATA_IN))
    else $error("vendor low byte write lost");
  a_read_answer: assert property ( // [RULE10]
    (RD_EN_IN && ADDR_IN == OFF_VALIDITY) |=> RVALID_OUT && RDATA_OUT == $past(eeprom_validity_byte))
    else $error("validity byte read wrong");
  a_load_length: assert property ( // [RULE3] [RULE4]
    (load_state == IDCFG_LD_SIG && EE_VALID_IN && EE_BYTE_IN == VALIDITY_PATTERN)
      ##1 (EE_VALID_IN [*4]) |=> LOAD_DONE_OUT && !LOAD_ABORT_OUT)
    else $error("load did not finish after four data bytes");

  // Host byte writes land exactly where the map puts them.
  a_vendor_hi_wr: assert property ( // [RULE9]
    (host_wr && ADDR_IN == OFF_VENDOR_HI) |=> vendor_code_written[15:8] == $past(WDATA_IN))
    else $error("vendor high byte write lost");
  a_product_lo_wr: assert property ( // [RULE4]
    (host_wr && ADDR_IN == OFF_PRODUCT_LO) |=> product_code_written[7:0] == $past(WDATA_IN))
    else $error("product low byte write lost");
  a_product_hi_wr: assert property ( // [RULE4]
    (host_wr && ADDR_IN == OFF_PRODUCT_HI) |=> product_code_written[15:8] == $past(WDATA_IN))
    else $error("product high byte write lost");
  a_validity_wr: assert property ( // [RULE10]
    (host_wr && ADDR_IN == OFF_VALIDITY) |=> eeprom_validity_byte == $past(WDATA_IN))
    else $error("validity byte write lost");

  // A half-written pair must leave the next source in use.
  a_mixed_keeps_otp: assert property ( // [RULE12]
    (vendor_code_written != 16'h0000 && product_code_written == 16'h0000 &&
     OTP_VENDOR_IN != 16'h0000 && OTP_PRODUCT_IN != 16'h0000)
      |=> SOURCE_OUT == IDCFG_SRC_OTP && VENDOR_CODE_OUT == $past(OTP_VENDOR_IN))
    else $error("half-written codes displaced the OTP codes");

  // Reads show the value in use, unmapped offsets answer zero, and every answer has a strobe.
  a_read_vendor_hi: assert property ( // [RULE3]
    (RD_EN_IN && ADDR_IN == OFF_VENDOR_HI) |=> RDATA_OUT == $past(vendor_code[15:8]))
    else $error("vendor high byte read wrong");
  a_read_product_lo: assert property ( // [RULE4]
    (RD_EN_IN && ADDR_IN == OFF_PRODUCT_LO) |=> RDATA_OUT == $past(product_code[7:0]))
    else $error("product low byte read wrong");
  a_unmapped_read: assert property ( // [RULE11]
    (RD_EN_IN && ADDR_IN > OFF_LAST) |=> RDATA_OUT == READ_UNMAPPED)
    else $error("unmapped offset did not read zero");
  a_read_pulse: assert property (RVALID_OUT |-> $past(RD_EN_IN)) // [RULE11]
    else $error("read answer without a read strobe");

  // Loader status stands until the next start, and the byte port closes with it.
  a_done_not_ready: assert property (LOAD_DONE_OUT |-> !EE_READY_OUT) // [RULE2]
    else $error("loader still asks for bytes after it finished");
  a_abort_done: assert property (LOAD_ABORT_OUT |-> LOAD_DONE_OUT) // [RULE2]
    else $error("abort shown without done");
  a_done_holds: assert property ( // [RULE2]
    (LOAD_DONE_OUT && !EE_START_IN) |=> LOAD_DONE_OUT)
    else $error("done dropped without a new start");
  a_start_opens: assert property ( // [RULE1]
    (EE_START_IN && CFG_MODE_IN == IDCFG_MODE_I2C && !EE_READY_OUT)
      |=> EE_READY_OUT && !LOAD_DONE_OUT && !LOAD_ABORT_OUT)
    else $error("start in I2C mode did not open the signature phase");
  a_data_offsets: assert property ( // [RULE3]
    (load_state == IDCFG_LD_DATA) |-> (load_off >= OFF_VENDOR_LO && load_off <= OFF_LAST))
    else $error("loader offset left the identifier bytes");
  a_abort_clears_all: assert property ( // [RULE2]
    (load_state == IDCFG_LD_SIG && EE_VALID_IN && EE_BYTE_IN != VALIDITY_PATTERN)
      |=> product_code_written == 16'h0000 && eeprom_validity_byte == VALIDITY_RESET)
    else $error("bad signature left written values behind");

  // Covers for the main load and selection outcomes.
  c_load_ok: cover property (LOAD_DONE_OUT && !LOAD_ABORT_OUT);
  c_load_abort: cover property (LOAD_ABORT_OUT);
  c_otp_used: cover property (SOURCE_OUT == IDCFG_SRC_OTP);
  c_written_used: cover property (SOURCE_OUT == IDCFG_SRC_WRITTEN);
  c_default_used: cover property (SOURCE_OUT == IDCFG_SRC_DEFAULT);
endmodule : idcfg_bank

// file: hw/idcfg_pkg.sv
// Package for the identification configuration bank: offsets, encodings and reset values.
// Assumes one clock domain and byte-wide register access.
package idcfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ID_W = 16;

  localparam logic [7:0] OFF_VALIDITY = 8'h00;
  localparam logic [7:0] OFF_VENDOR_LO = 8'h01;
  localparam logic [7:0] OFF_VENDOR_HI = 8'h02;
  localparam logic [7:0] OFF_PRODUCT_LO = 8'h03;
  localparam logic [7:0] OFF_PRODUCT_HI = 8'h04;
  localparam logic [7:0] OFF_LAST = OFF_PRODUCT_HI;

  localparam logic [7:0] VALIDITY_PATTERN = 8'h55;
  localparam logic [7:0] VALIDITY_RESET = 8'h00;
  localparam logic [15:0] WRITTEN_RESET = 16'h0000;
  localparam logic [7:0] USB2_PRODUCT_XOR = 8'h02;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    IDCFG_MODE_PINS = 2'h0,
    IDCFG_MODE_I2C = 2'h1,
    IDCFG_MODE_SMBUS = 2'h2
  } idcfg_mode_t;

  typedef enum logic [1:0] {
    IDCFG_SRC_WRITTEN = 2'h0,
    IDCFG_SRC_OTP = 2'h1,
    IDCFG_SRC_DEFAULT = 2'h2
  } idcfg_src_t;

  // Gray order along the load path: idle, signature, data, done.
  typedef enum logic [1:0] {
    IDCFG_LD_IDLE = 2'b00,
    IDCFG_LD_SIG = 2'b01,
    IDCFG_LD_DATA = 2'b11,
    IDCFG_LD_DONE = 2'b10
  } idcfg_load_t;
endpackage : idcfg_pkg

// file: tb/id_config_select_tb.sv
// Self-checking bench for the identification configuration bank.
// Assumes the bank's default codes are set here and the EEPROM model drives the load port.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module id_config_select_tb;
  import idcfg_pkg::*;
  localparam logic [15:0] DEF_VEN = 16'h1A2B; // Arbitrary value.
  localparam logic [15:0] DEF_PRO = 16'h3C4D; // Arbitrary value.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  idcfg_mode_t mode = IDCFG_MODE_PINS;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ee_start = 1'b0;
  logic slow = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [15:0] otp_ven = 16'h0000;
  logic [15:0] otp_pro = 16'h0000;
  logic [39:0] image = 40'h12345678_55;
  logic rvalid, ee_valid, ee_ready, ld_done, ld_abort;
  logic [7:0] rdata, ee_byte;
  logic [15:0] ven, pss, pu2;
  idcfg_src_t src;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  idcfg_bank #(.DEFAULT_VENDOR(DEF_VEN), .DEFAULT_PRODUCT(DEF_PRO)) uut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .CFG_MODE_IN(mode), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
    .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
    .EE_START_IN(ee_start), .EE_VALID_IN(ee_valid), .EE_BYTE_IN(ee_byte),
    .EE_READY_OUT(ee_ready), .LOAD_DONE_OUT(ld_done), .LOAD_ABORT_OUT(ld_abort),
    .OTP_VENDOR_IN(otp_ven), .OTP_PRODUCT_IN(otp_pro), .VENDOR_CODE_OUT(ven),
    .PRODUCT_SS_OUT(pss), .PRODUCT_USB2_OUT(pu2), .SOURCE_OUT(src));
  idcfg_ee_model ee (.clk_in(clk), .rst_n_in(rst_n), .start_in(ee_start), .ready_in(ee_ready),
    .slow_in(slow), .image_in(image), .valid_out(ee_valid), .byte_out(ee_byte));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    wr_en = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_en = 1'b1;
    addr = a;
    tick(1);
    rd_en = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
    tick(1);
  endtask : rd_chk
  task automatic codes_chk(input logic [15:0] v, input logic [15:0] p, input idcfg_src_t s);
    tick(2);
    `CHK(ven, v)
    `CHK(pss, p)
    `CHK(pu2, p ^ 16'h0002)
    `CHK(src, s)
    rd_chk(8'h01, v[7:0]);
    rd_chk(8'h02, v[15:8]);
    rd_chk(8'h03, p[7:0]);
    rd_chk(8'h04, p[15:8]);
  endtask : codes_chk
  task automatic t_defaults;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(1);
    codes_chk(DEF_VEN, DEF_PRO, IDCFG_SRC_DEFAULT);
    rd_chk(8'h00, 8'h00);
  endtask : t_defaults
  task automatic t_otp;
    otp_ven = 16'h9A7C;
    otp_pro = 16'h5E31;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    codes_chk(otp_ven, otp_pro, IDCFG_SRC_OTP);
  endtask : t_otp
  task automatic t_host;
    wr(8'h00, 8'hA5);
    rd_chk(8'h00, 8'h00);
    mode = IDCFG_MODE_SMBUS;
    wr(8'h00, 8'h5A);
    rd_chk(8'h00, 8'h5A);
    rd_chk(8'h05, 8'h00);
    wr(8'h01, 8'hEF);
    wr(8'h02, 8'hBE);
    codes_chk(otp_ven, otp_pro, IDCFG_SRC_OTP);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h01);
    codes_chk(16'hBEEF, 16'h0100, IDCFG_SRC_WRITTEN);
  endtask : t_host
  task automatic t_load(input logic [7:0] sig, input logic fast);
    int n;
    n = 0;
    mode = IDCFG_MODE_I2C;
    image[7:0] = sig;
    slow = !fast;
    ee_start = 1'b1;
    tick(1);
    ee_start = 1'b0;
    while (ld_done !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    `CHK(ld_done, 1'b1)
    `CHK(ld_abort, sig != 8'h55)
    `CHK(ee_ready, 1'b0)
  endtask : t_load
  initial begin
    t_defaults();
    t_otp();
    t_host();
    t_load(8'h55, 1'b0);
    codes_chk(16'h5678, 16'h1234, IDCFG_SRC_WRITTEN);
    rd_chk(8'h00, 8'h55);
    t_load(8'hAA, 1'b1);
    codes_chk(otp_ven, otp_pro, IDCFG_SRC_OTP);
    rd_chk(8'h00, 8'h00);
    t_load(8'h55, 1'b1);
    codes_chk(16'h5678, 16'h1234, IDCFG_SRC_WRITTEN);
    wr(8'h00, 8'hC3);
    rd_chk(8'h00, 8'hC3);
    end_sim();
  end
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule : id_config_select_tb

// file: tb/idcfg_ee_model.sv
// Behavioural serial EEPROM seen through the device's byte reader.
// Assumes a start pulse per load and a valid/ready byte handshake.
`timescale 1ns/1ps
module idcfg_ee_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic ready_in,
  input wire logic slow_in,
  input wire logic [39:0] image_in,
  output logic valid_out,
  output logic [7:0] byte_out
);
  logic [2:0] idx;
  logic active;
  logic last;
  // The reader stops after the product high byte or a bad validity byte.
  assign last = (idx == 3'h4) || (idx == 3'h0 && byte_out != 8'h55);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active <= 1'b0;
      idx <= 3'h0;
      valid_out <= 1'b0;
      byte_out <= 8'hFF;
    end else if (start_in) begin
      active <= 1'b1;
      idx <= 3'h0;
      valid_out <= 1'b1;
      byte_out <= image_in[7:0];
    end else if (valid_out && ready_in) begin
      idx <= idx + 3'h1;
      active <= !last;
      if (slow_in || last) begin
        valid_out <= 1'b0;
        byte_out <= ~byte_out;
      end else begin
        byte_out <= image_in[8*(idx+1) +: 8];
      end
    end else if (active && !valid_out) begin
      valid_out <= 1'b1;
      byte_out <= image_in[8*idx +: 8];
    end else if (!valid_out) begin
      // An idle line flips the byte every cycle, so the last byte shows again only on alternate cycles.
      byte_out <= ~byte_out;
    end
  end
endmodule : idcfg_ee_model
